// [rtl/lcd_pkg.sv]
/*
 package for the lcd scan timing block: drive modes, geometry, divider and reset constants.
 assumes a 200 MHz system clock and a command decoder that sets mode and pointer.
*/
// Functional notes
// RQ1 - frame is active clock divided by 2880 normally, 480 in power saving
// RQ2 - internal clock: power mode fixes frame rate; external clock rate sets it
// RQ3 - strap low: internal oscillator runs and is driven out on clock pin
// RQ4 - strap high: oscillator stopped, clock pin is an external clock input
// RQ5 - system keeps device clock above 125 kHz for full serial rate
// RQ6 - system never stops the clock, else outputs freeze at DC
// RQ7 - byte arriving while previous is stored holds serial clock low, nothing lost
// RQ8 - shared sync signal keeps cascaded drivers frame aligned
// RQ9 - shift register loads next row from RAM while current row shows
// RQ10 - display register stays steady while its row is being output
// RQ11 - forty segment outputs follow display register with backplane timing
// RQ12 - four backplanes; four-way mode gives each its own signal
// RQ13 - three-way mode: fourth backplane copies second
// RQ14 - two-way mode: first equals third, second equals fourth
// RQ15 - static mode: all four backplanes identical
// RQ16 - display memory is forty 4-bit columns, one bit per element
// RQ17 - stored 1 turns element on, stored 0 turns it off
// RQ18 - rows 0-3 map to backplanes 0-3, columns 0-39 to segments
// RQ19 - display bytes are stored on arrival, no acknowledge wait
// RQ20 - bits stored one to four per column by multiplex mode
// RQ21 - three-backplane panel uses three-way, four-backplane uses four-way
// RQ22 - reset gives four-way mode, blink off, cleared data pointer
// RQ23 - slots run ascending, equal length, each selecting its RAM row
package lcd_pkg;
   typedef enum logic [1:0] {LCD_STATIC, LCD_MUX2, LCD_MUX3, LCD_MUX4} lcd_mode_e;
   localparam int NUM_COLS = 40;
   localparam int NUM_ROWS = 4;
   localparam logic [5:0] LAST_COL = 6'h27;
   localparam int DIV_NORMAL = 2880;
   localparam int DIV_SAVE = 480;
   localparam int SYS_CLK_KHZ = 200000;
   localparam int OSC_FREQ_KHZ = 200;
   localparam int OSC_HALF_CYC = SYS_CLK_KHZ / (2 * OSC_FREQ_KHZ);
   localparam logic [9:0] OSC_HALF_LAST = 10'(OSC_HALF_CYC - 1);
   localparam lcd_mode_e MODE_RESET = LCD_MUX4;
   localparam logic SAVE_RESET = 1'b0;
   localparam logic [5:0] PTR_RESET = 6'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // ticks per backplane slot; frame = slots times this
   function automatic logic [11:0] slot_len(input logic save, input lcd_mode_e mode);
      int div;
      div = save ? DIV_SAVE : DIV_NORMAL;
      unique case (mode)
         LCD_STATIC: slot_len = 12'(div);
         LCD_MUX2: slot_len = 12'(div / 2);
         LCD_MUX3: slot_len = 12'(div / 3);
         LCD_MUX4: slot_len = 12'(div / 4);
      endcase
   endfunction : slot_len
endpackage : lcd_pkg

// [rtl/lcd_slot_timer.sv]
/*
 slot and frame counter: counts clock ticks into equal backplane slots.
 assumes i_tick is a one-cycle pulse per active lcd clock period.
*/
`timescale 1ns/1ps
module lcd_slot_timer (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_restart,
   input wire logic [11:0] i_slot_len,
   input wire logic [1:0] i_last_slot,
   output logic [1:0] o_slot,
   output logic o_slot_end,
   output logic o_frame_end
);
   logic [11:0] cnt_reg;
   logic [11:0] cnt_next;
   logic [1:0] slot_reg;
   logic [1:0] slot_next;

   always_comb begin
      o_slot = slot_reg;
      o_slot_end = i_tick && (cnt_reg >= 12'(i_slot_len - 12'h001)); // RQ23
      o_frame_end = o_slot_end && (slot_reg >= i_last_slot);
      cnt_next = cnt_reg;
      slot_next = slot_reg;
      if (i_restart) begin
         cnt_next = 12'h000; // RQ8
         slot_next = 2'h0;
      end else if (o_slot_end) begin
         cnt_next = 12'h000;
         slot_next = o_frame_end ? 2'h0 : 2'(slot_reg + 2'h1); // RQ23
      end else if (i_tick) begin
         cnt_next = 12'(cnt_reg + 12'h001);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 12'h000;
         slot_reg <= 2'h0;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
         slot_reg <= slot_next;
      end
   end
endmodule : lcd_slot_timer

// [rtl/lcd_scan_timing.sv]
/*
 lcd scan timing: clock source select, frame divider, display RAM store engine with
 serial clock hold, shift and display registers, backplane and segment outputs.
 assumes command decoder pulses for mode set, pointer load and received display bytes;
 all inputs synchronous to I_CLK_SYS.
*/
`timescale 1ns/1ps
module lcd_scan_timing (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic I_CE,
   input wire logic I_OSC_SEL,
   input wire logic I_CLK_PIN_IN,
   output logic O_CLK_PIN_OUT,
   output logic O_CLK_PIN_OE_N,
   input wire logic I_SYNC_IN,
   output logic O_SYNC_OUT,
   output logic O_SYNC_OE_N,
   input wire logic I_MODE_SET,
   input wire lcd_pkg::lcd_mode_e I_MODE,
   input wire logic I_POWER_SAVE,
   input wire logic I_PTR_LOAD,
   input wire logic [5:0] I_PTR_VAL,
   input wire logic I_BYTE_VALID,
   input wire logic [7:0] I_BYTE_DATA,
   output logic O_SCL_HOLD,
   output logic O_BACKPLANE_OUT_0,
   output logic O_BACKPLANE_OUT_1,
   output logic O_BACKPLANE_OUT_2,
   output logic O_BACKPLANE_OUT_3,
   output logic [39:0] O_SEGMENT_OUT
);
   import lcd_pkg::*;

   typedef enum logic {ST_IDLE, ST_STORE} lcd_store_e;

   // clock source group
   logic strap_reg, strap_next, strap_done_reg, strap_done_next;
   logic [9:0] osc_cnt_reg, osc_cnt_next;
   logic osc_reg, osc_next, ext_prev_reg, ext_prev_next, clk_oe_n_reg, clk_oe_n_next;
   logic tick;
   // mode group
   lcd_mode_e mode_reg, mode_next;
   logic save_reg, save_next;
   // store group
   lcd_store_e st_reg, st_next;
   logic [7:0] act_reg, act_next, pend_reg, pend_next, shifted;
   logic [3:0] bit_reg, bit_next, nbits;
   logic [5:0] ptr_reg, ptr_next;
   logic pend_full_reg, pend_full_next, hold_reg, hold_next;
   logic wr_en;
   logic [3:0] wr_mask, wr_bits;
   logic [3:0] mem [0:NUM_COLS-1];
   // scan group
   logic [39:0] sh_reg, sh_next, disp_reg, disp_next, seg_reg, seg_next;
   logic [5:0] sh_cnt_reg, sh_cnt_next;
   logic sh_busy_reg, sh_busy_next, inv_reg, inv_next;
   logic [1:0] sh_row_reg, sh_row_next, slot, next_slot;
   logic [3:0] bp_reg, bp_next;
   logic sync_oe_n_reg, sync_oe_n_next, sync_prev_reg, sync_prev_next, restart;
   logic slot_end, frame_end;

   // clock source: strap caught after reset release, then held
   always_comb begin
      strap_next = strap_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg) begin
         strap_next = I_OSC_SEL;
      end
      osc_cnt_next = osc_cnt_reg;
      osc_next = osc_reg;
      if (strap_done_reg && !strap_reg) begin // RQ3
         osc_cnt_next = (osc_cnt_reg == OSC_HALF_LAST) ? 10'h000 : 10'(osc_cnt_reg + 10'h001);
         if (osc_cnt_reg == OSC_HALF_LAST) begin
            osc_next = ~osc_reg;
         end
      end
      ext_prev_next = I_CLK_PIN_IN;
      clk_oe_n_next = !strap_done_reg || strap_reg; // RQ3 RQ4
      if (!strap_done_reg) begin
         tick = 1'b0;
      end else if (strap_reg) begin
         tick = I_CLK_PIN_IN && !ext_prev_reg; // RQ4 RQ2
      end else begin
         tick = (osc_cnt_reg == OSC_HALF_LAST) && !osc_reg; // RQ2
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         strap_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         osc_cnt_reg <= 10'h000;
         osc_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         clk_oe_n_reg <= 1'b1;
      end else if (I_CE) begin
         strap_reg <= strap_next;
         strap_done_reg <= strap_done_next;
         osc_cnt_reg <= osc_cnt_next;
         osc_reg <= osc_next;
         ext_prev_reg <= ext_prev_next;
         clk_oe_n_reg <= clk_oe_n_next;
      end
   end

   // mode set command; reset is four-way, normal power
   always_comb begin
      mode_next = I_MODE_SET ? I_MODE : mode_reg; // RQ21
      save_next = I_MODE_SET ? I_POWER_SAVE : save_reg;
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         mode_reg <= MODE_RESET; // RQ22
         save_reg <= SAVE_RESET;
      end else if (I_CE) begin
         mode_reg <= mode_next;
         save_reg <= save_next;
      end
   end

   // store engine: one column per cycle, n bits per column, msb first
   always_comb begin
      st_next = st_reg;
      act_next = act_reg;
      bit_next = bit_reg;
      ptr_next = ptr_reg;
      pend_next = pend_reg;
      pend_full_next = pend_full_reg;
      wr_en = 1'b0;
      wr_mask = 4'h0;
      wr_bits = 4'h0;
      nbits = 4'({2'b00, mode_reg} + 4'h1);
      shifted = 8'(act_reg << bit_reg);
      if (st_reg == ST_STORE) begin
         wr_en = 1'b1; // RQ19
         for (int r = 0; r < NUM_ROWS; r++) begin
            if (r < int'(nbits) && int'(bit_reg) + r < 8) begin // RQ20
               wr_mask[r] = 1'b1;
               wr_bits[r] = shifted[7-r];
            end
         end
         ptr_next = (ptr_reg == LAST_COL) ? PTR_RESET : 6'(ptr_reg + 6'h01);
         if (4'(bit_reg + nbits) >= BYTE_BITS) begin
            bit_next = 4'h0;
            if (pend_full_reg) begin
               act_next = pend_reg; // RQ7
               pend_full_next = 1'b0;
            end else begin
               st_next = ST_IDLE;
            end
         end else begin
            bit_next = 4'(bit_reg + nbits);
         end
      end else if (I_PTR_LOAD) begin
         ptr_next = I_PTR_VAL;
      end
      if (I_BYTE_VALID) begin
         if (st_next == ST_IDLE) begin
            act_next = I_BYTE_DATA; // RQ19
            bit_next = 4'h0;
            st_next = ST_STORE;
         end else if (!pend_full_next) begin
            pend_next = I_BYTE_DATA; // RQ7
            pend_full_next = 1'b1;
         end
      end
      hold_next = pend_full_next; // RQ7
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         st_reg <= ST_IDLE;
         act_reg <= 8'h00;
         bit_reg <= 4'h0;
         ptr_reg <= PTR_RESET; // RQ22
         pend_reg <= 8'h00;
         pend_full_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else if (I_CE) begin
         st_reg <= st_next;
         act_reg <= act_next;
         bit_reg <= bit_next;
         ptr_reg <= ptr_next;
         pend_reg <= pend_next;
         pend_full_reg <= pend_full_next;
         hold_reg <= hold_next;
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         for (int c = 0; c < NUM_COLS; c++) begin
            mem[c] <= 4'h0; // RQ16
         end
      end else if (I_CE && wr_en) begin
         for (int r = 0; r < NUM_ROWS; r++) begin
            if (wr_mask[r]) begin
               mem[ptr_reg][r] <= wr_bits[r];
            end
         end
      end
   end

   lcd_slot_timer u_timer (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_ce(I_CE),
      .i_tick(tick),
      .i_restart(restart),
      .i_slot_len(slot_len(save_reg, mode_reg)), // RQ1
      .i_last_slot(2'(mode_reg)),
      .o_slot(slot),
      .o_slot_end(slot_end),
      .o_frame_end(frame_end)
   );

   // scan: shift next row while current shows, swap at slot end
   always_comb begin
      restart = !I_SYNC_IN && sync_prev_reg && sync_oe_n_reg; // RQ8
      next_slot = frame_end ? 2'h0 : 2'(slot + 2'h1);
      sh_next = sh_reg;
      sh_cnt_next = sh_cnt_reg;
      sh_busy_next = sh_busy_reg;
      sh_row_next = sh_row_reg;
      disp_next = disp_reg;
      inv_next = inv_reg;
      if (sh_busy_reg) begin
         sh_next = {mem[sh_cnt_reg][sh_row_reg], sh_reg[39:1]}; // RQ9 RQ18
         sh_cnt_next = 6'(sh_cnt_reg + 6'h01);
         sh_busy_next = (sh_cnt_reg != LAST_COL);
      end
      if (slot_end) begin
         disp_next = sh_reg; // RQ10
         sh_row_next = (next_slot == 2'(mode_reg)) ? 2'h0 : 2'(next_slot + 2'h1);
         sh_cnt_next = 6'h00;
         sh_busy_next = 1'b1;
         inv_next = frame_end ? ~inv_reg : inv_reg;
      end
      for (int k = 0; k < NUM_ROWS; k++) begin
         unique case (mode_reg)
            LCD_STATIC: bp_next[k] = (slot == 2'h0) ^ inv_reg; // RQ15
            LCD_MUX2: bp_next[k] = (slot == {1'b0, 1'(k)}) ^ inv_reg; // RQ14
            LCD_MUX3: bp_next[k] = (slot == ((k == 3) ? 2'h1 : 2'(k))) ^ inv_reg; // RQ13
            LCD_MUX4: bp_next[k] = (slot == 2'(k)) ^ inv_reg; // RQ12
         endcase
      end
      seg_next = disp_reg ^ {40{inv_reg}}; // RQ11 RQ17
      sync_oe_n_next = !frame_end; // RQ8
      sync_prev_next = I_SYNC_IN;
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         sh_reg <= 40'h00_0000_0000;
         sh_cnt_reg <= 6'h00;
         sh_busy_reg <= 1'b1;
         sh_row_reg <= 2'h0;
         disp_reg <= 40'h00_0000_0000;
         inv_reg <= 1'b0;
         bp_reg <= 4'h0;
         seg_reg <= 40'h00_0000_0000;
         sync_oe_n_reg <= 1'b1;
         sync_prev_reg <= 1'b1;
      end else if (I_CE) begin
         sh_reg <= sh_next;
         sh_cnt_reg <= sh_cnt_next;
         sh_busy_reg <= sh_busy_next;
         sh_row_reg <= sh_row_next;
         disp_reg <= disp_next;
         inv_reg <= inv_next;
         bp_reg <= bp_next;
         seg_reg <= seg_next;
         sync_oe_n_reg <= sync_oe_n_next;
         sync_prev_reg <= sync_prev_next;
      end
   end

   always_comb begin
      O_CLK_PIN_OUT = osc_reg;
      O_CLK_PIN_OE_N = clk_oe_n_reg;
      O_SYNC_OUT = 1'b0 & sync_prev_reg;
      O_SYNC_OE_N = sync_oe_n_reg;
      O_SCL_HOLD = hold_reg;
      O_BACKPLANE_OUT_0 = bp_reg[0];
      O_BACKPLANE_OUT_1 = bp_reg[1];
      O_BACKPLANE_OUT_2 = bp_reg[2];
      O_BACKPLANE_OUT_3 = bp_reg[3];
      O_SEGMENT_OUT = seg_reg;
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);

   chk_bp_three_way: assert property ($past(I_CE) && $past(mode_reg) == LCD_MUX3 |-> // RQ13
      O_BACKPLANE_OUT_3 == O_BACKPLANE_OUT_1) else $error("fourth backplane differs");
   chk_bp_two_way: assert property ($past(I_CE) && $past(mode_reg) == LCD_MUX2 |-> // RQ14
      O_BACKPLANE_OUT_0 == O_BACKPLANE_OUT_2 && O_BACKPLANE_OUT_1 == O_BACKPLANE_OUT_3)
      else $error("two-way backplane pairs differ");
   chk_bp_static: assert property ($past(I_CE) && $past(mode_reg) == LCD_STATIC |-> // RQ15
      bp_reg == 4'h0 || bp_reg == 4'hF) else $error("static backplanes differ");
   chk_scl_hold_set: assert property (I_CE && I_BYTE_VALID && st_reg == ST_STORE // RQ7
      && !pend_full_reg && 4'(bit_reg + nbits) < BYTE_BITS |=> O_SCL_HOLD)
      else $error("serial clock not held");
   chk_scl_hold_ends: assert property ($rose(O_SCL_HOLD) |-> ##[1:20] !O_SCL_HOLD) // RQ7
      else $error("serial clock held too long");
   chk_disp_steady: assert property (!(I_CE && slot_end) |=> $stable(disp_reg)) // RQ10
      else $error("display register changed mid slot");
   chk_sync_frame: assert property (I_CE && frame_end |=> !O_SYNC_OE_N) // RQ8
      else $error("sync not driven at frame end");
   chk_slot_ascend: assert property (I_CE && slot_end && !frame_end && !restart |=> // RQ23
      slot == 2'($past(slot) + 2'h1)) else $error("slot order broken");
   chk_clk_pin_dir: assert property (strap_done_reg && I_CE |=> // RQ3 RQ4
      O_CLK_PIN_OE_N == strap_reg) else $error("clock pin direction wrong");

   cov_frame_mux4: cover property (mode_reg == LCD_MUX4 && frame_end);
   cov_hold: cover property ($rose(O_SCL_HOLD) ##[1:20] $fell(O_SCL_HOLD));
   cov_resync: cover property (restart);
endmodule : lcd_scan_timing

// [sim/lcd_far_side.sv]
/*
 far side model: cascaded driver that supplies the external lcd clock and shares the sync wire.
 assumes the bench clock; sync wire has a pull-up and is low while either party pulls it.
*/
`timescale 1ns/1ps
module lcd_far_side (
   input wire logic i_clk,
   input wire logic [3:0] i_half,
   input wire logic i_pull,
   input wire logic i_sync_oe_n,
   output logic o_ext_clk,
   output logic o_sync_wire
);
   logic [3:0] cnt_reg = 4'h0;
   logic ext_reg = 1'b0;
   // clock never stops; i_half sets how fast or slow it runs
   always @(posedge i_clk) begin
      if (cnt_reg + 4'h1 >= i_half) begin
         cnt_reg <= 4'h0;
         ext_reg <= ~ext_reg;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   assign o_ext_clk = ext_reg;
   assign o_sync_wire = i_sync_oe_n & ~i_pull;
endmodule : lcd_far_side

// [sim/lcd_scan_timing_test.sv]
/*
 self-checking bench for the lcd scan timing block.
 assumes lcd_far_side as clock source and sync partner; expected data from a bench RAM model.
*/
`timescale 1ns/1ps
module lcd_scan_timing_test;
   import lcd_pkg::*;
   logic clk, rst, ce, osc_sel, mode_set, psave, ptr_load, bval, pull;
   lcd_mode_e mode, cur_mode;
   logic cur_save;
   logic [5:0] ptr_val;
   logic [7:0] bdata;
   logic [3:0] half;
   logic clk_out, clk_oe_n, sync_out, sync_oe_n, scl_hold, ext_clk, sync_wire;
   logic [3:0] bp;
   logic [39:0] seg;
   logic [3:0] ram_m [40];
   int mp;
   int errors = 0;
   int checks_done = 0;

   lcd_far_side fm (.i_clk(clk), .i_half(half), .i_pull(pull), .i_sync_oe_n(sync_oe_n),
      .o_ext_clk(ext_clk), .o_sync_wire(sync_wire));
   lcd_scan_timing uut (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(ce), .I_OSC_SEL(osc_sel),
      .I_CLK_PIN_IN(ext_clk), .O_CLK_PIN_OUT(clk_out), .O_CLK_PIN_OE_N(clk_oe_n),
      .I_SYNC_IN(sync_wire), .O_SYNC_OUT(sync_out), .O_SYNC_OE_N(sync_oe_n),
      .I_MODE_SET(mode_set), .I_MODE(mode), .I_POWER_SAVE(psave), .I_PTR_LOAD(ptr_load),
      .I_PTR_VAL(ptr_val), .I_BYTE_VALID(bval), .I_BYTE_DATA(bdata), .O_SCL_HOLD(scl_hold),
      .O_BACKPLANE_OUT_0(bp[0]), .O_BACKPLANE_OUT_1(bp[1]), .O_BACKPLANE_OUT_2(bp[2]),
      .O_BACKPLANE_OUT_3(bp[3]), .O_SEGMENT_OUT(seg));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_vec

   task automatic chk_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_num(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask : chk_num

   task automatic wrap_up;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   task automatic do_reset(input logic sel);
      @(posedge clk);
      rst <= 1'b1;
      osc_sel <= sel;
      repeat (2) @(posedge clk);
      chk_vec(seg, 40'h00_0000_0000);
      chk_vec(40'({clk_out, sync_out, bp, scl_hold, sync_oe_n, clk_oe_n}), 40'h3);
      rst <= 1'b0;
      foreach (ram_m[i]) ram_m[i] = 4'h0;
      cur_mode = LCD_MUX4;
      cur_save = 1'b0;
      mp = 0;
   endtask : do_reset

   // one pulse per frame end; returns cycles waited
   task automatic wait_sync(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (sync_oe_n !== 1'b0 && n < 20000);
   endtask : wait_sync

   task automatic set_mode(input lcd_mode_e m, input logic s);
      @(posedge clk);
      mode_set <= 1'b1;
      mode <= m;
      psave <= s;
      @(posedge clk);
      mode_set <= 1'b0;
      cur_mode = m;
      cur_save = s;
   endtask : set_mode

   task automatic put_ptr(input logic [5:0] p);
      @(posedge clk);
      ptr_load <= 1'b1;
      ptr_val <= p;
      @(posedge clk);
      ptr_load <= 1'b0;
      mp = int'(p);
   endtask : put_ptr

   // caller lowers bval afterwards; model fills mode+1 rows per column, msb first
   task automatic put_byte(input logic [7:0] b);
      int n;
      n = int'(cur_mode) + 1;
      @(posedge clk);
      bval <= 1'b1;
      bdata <= b;
      for (int i = 7; i >= 0; i--) begin
         ram_m[mp][(7 - i) % n] = b[i];
         if ((7 - i) % n == n - 1 || i == 0) mp = (mp == 39) ? 0 : mp + 1;
      end
   endtask : put_byte

   function automatic logic [3:0] exp_bp(input int k, input logic inv);
      logic [3:0] v;
      case (cur_mode)
         LCD_STATIC: v = 4'hF;
         LCD_MUX2: v = (k == 0) ? 4'h5 : 4'hA;
         LCD_MUX3: v = (k == 1) ? 4'hA : 4'(1 << k);
         default: v = 4'(1 << k);
      endcase
      return v ^ {4{inv}};
   endfunction : exp_bp

   // samples mid-slot over two settled frames; inversion flips between them
   task automatic check_scan;
      int n, sc, w;
      logic inv;
      logic [39:0] e;
      n = int'(cur_mode) + 1;
      sc = (cur_save ? DIV_SAVE : DIV_NORMAL) / n * 2 * int'(half);
      wait_sync(w);
      wait_sync(w);
      for (int f = 0; f < 2; f++) begin
         wait_sync(w);
         for (int k = 0; k < n; k++) begin
            repeat ((k == 0) ? sc / 2 : sc) @(negedge clk);
            if (f == 0 && k == 0) inv = ~bp[0];
            chk_vec(40'(bp), 40'(exp_bp(k, inv ^ f[0])));
            for (int c = 0; c < 40; c++) e[c] = ram_m[c][k] ^ inv ^ f[0];
            chk_vec(seg, e);
         end
      end
   endtask : check_scan

   task automatic chk_frame(input int exp);
      int w;
      repeat (3) wait_sync(w);
      chk_num(w, exp - 1, exp + 1);
   endtask : chk_frame

   task automatic t_osc;
      int n;
      do_reset(1'b0);
      repeat (4) @(negedge clk);
      chk_bit(clk_oe_n, 1'b0);
      @(posedge clk_out);
      n = 0;
      while (clk_out === 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk_num(n, OSC_HALF_CYC - 1, OSC_HALF_CYC + 1);
   endtask : t_osc

   task automatic t_ext;
      int n;
      logic c0;
      do_reset(1'b1);
      c0 = clk_out;
      n = 0;
      repeat (1200) begin
         @(negedge clk);
         n += int'(clk_out !== c0) + int'(clk_oe_n !== 1'b1);
      end
      chk_num(n, 0, 0);
      check_scan();
      chk_frame(2 * DIV_NORMAL);
   endtask : t_ext

   task automatic t_rate;
      set_mode(LCD_MUX4, 1'b1);
      chk_frame(2 * DIV_SAVE);
      @(posedge clk);
      half <= 4'h2;
      chk_frame(4 * DIV_SAVE);
      @(posedge clk);
      half <= 4'h1;
   endtask : t_rate

   // two bytes back to back in static mode, wrapping past the last column
   task automatic t_hold;
      int n;
      set_mode(LCD_STATIC, 1'b1);
      put_ptr(6'h1E);
      put_byte(8'hC5);
      put_byte(8'h3A);
      @(posedge clk);
      bval <= 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(scl_hold, 1'b1);
      n = 0;
      while (scl_hold === 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk_num(n, 1, 8);
      repeat (20) @(posedge clk);
      check_scan();
   endtask : t_hold

   task automatic t_modes;
      for (int m = 1; m < 4; m++) begin
         set_mode(lcd_mode_e'(m), 1'b1);
         put_ptr(6'h05);
         put_byte(8'h96 ^ 8'(m));
         @(posedge clk);
         bval <= 1'b0;
         repeat (20) @(posedge clk);
         check_scan();
      end
   endtask : t_modes

   // partner pulls sync mid-frame; own frame end must follow one full frame later
   task automatic t_sync;
      int w;
      wait_sync(w);
      repeat (300) @(posedge clk);
      pull <= 1'b1;
      @(posedge clk);
      pull <= 1'b0;
      wait_sync(w);
      chk_num(w, 2 * DIV_SAVE - 4, 2 * DIV_SAVE + 6);
   endtask : t_sync

   // clock enable low for longer than a slot: segment, backplane, sync enable and hold outputs may not move
   task automatic t_freeze;
      int n;
      logic [45:0] v;
      @(posedge clk);
      ce <= 1'b0;
      @(negedge clk);
      v = {seg, bp, sync_oe_n, scl_hold};
      n = 0;
      repeat (1000) begin
         @(negedge clk);
         n += int'({seg, bp, sync_oe_n, scl_hold} !== v);
      end
      chk_num(n, 0, 0);
      @(posedge clk);
      ce <= 1'b1;
   endtask : t_freeze

   initial begin
      #500000;
      errors++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      osc_sel = 1'b0;
      mode_set = 1'b0;
      mode = LCD_MUX4;
      psave = 1'b0;
      ptr_load = 1'b0;
      ptr_val = 6'h00;
      bval = 1'b0;
      bdata = 8'h00;
      half = 4'h1;
      pull = 1'b0;
      t_osc();
      t_ext();
      t_rate();
      t_hold();
      t_modes();
      t_sync();
      t_freeze();
      wrap_up();
   end
endmodule : lcd_scan_timing_test
